// [cophs_pkg.sv]
// How it works
// - advance with qualifier requests next fetch
// - pass high for passed coprocessor instruction
// - pass held in busy-wait, dropped on interrupt
// - late cancel may come without coprocessor instruction
// - late cancel valid edge after first execute
// - decode handshake on entry, else execute handshake
// - absent handshake takes undefined trap
// - decode wait stalls core in busy-wait, execute wait holds ST_EXEC
// - busy-wait absent traps, go or last proceeds
// - go executes now, needs another cycle
// - load/store execute drives address and request low
// - absent 10, wait 00, go 01, last 11
package cophs_pkg;

   // ----------------------------------------------------------------
   // handshake encoding and widths
   // ----------------------------------------------------------------
   localparam logic [1:0] HS_ABSENT = 2'h2;
   localparam logic [1:0] HS_WAIT = 2'h0;
   localparam logic [1:0] HS_GO = 2'h1;
   localparam logic [1:0] HS_LAST = 2'h3;

   localparam int ADDR_W = 32;
   localparam int INSTR_W = 32;
   localparam int CNT_W = 8;

   localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [INSTR_W-1:0] INSTR_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // ----------------------------------------------------------------
   // execute sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_FIRST = 5'h02,
      ST_WAIT = 5'h04,
      ST_EXEC = 5'h08,
      ST_FINAL = 5'h10
   } cophs_state_type;

endpackage

// [cophs_xfer_count.sv]
`timescale 1ns/1ps
module cophs_xfer_count (
   input wire logic clk, // core clock
   input wire logic rst, // async reset, high
   input wire logic qual, // clock qualifier
   input wire logic load, // start of a new instruction
   input wire logic [cophs_pkg::ADDR_W-1:0] base, // first word address
   input wire logic step, // one word went out this cycle
   output logic [cophs_pkg::ADDR_W-1:0] addr_q, // current word address
   output logic [cophs_pkg::CNT_W-1:0] words_q // words issued so far
);

   // ----------------------------------------------------------------
   // word address and count
   // ----------------------------------------------------------------
   logic [cophs_pkg::ADDR_W-1:0] addr_d;
   logic [cophs_pkg::CNT_W-1:0] words_d;

   // load wins over step: a fresh instruction restarts the walk
   assign addr_d = load ? base : (step ? addr_q + cophs_pkg::WORD_STEP : addr_q);
   assign words_d = load ? cophs_pkg::CNT_RESET : (step ? words_q + cophs_pkg::CNT_ONE : words_q);

   // moves only on qualified edges, like the rest of the pipeline
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q <= cophs_pkg::ADDR_RESET;
         words_q <= cophs_pkg::CNT_RESET;
      end else if (qual) begin
         addr_q <= addr_d;
         words_q <= words_d;
      end
   end

endmodule

// [cophs_core_port.sv]
`timescale 1ns/1ps
module cophs_core_port (
   input wire logic CORE_CLK, // system clock
   input wire logic RESET, // async reset, high
   input wire logic CLOCK_QUALIFIER, // core clock qualifier
   input wire logic ADVANCE_REQ, // core pipeline wants to advance
   input wire logic [cophs_pkg::INSTR_W-1:0] FETCH_DATA, // word from instruction memory
   input wire logic EXEC_IS_COP, // entering instruction is coprocessor type
   input wire logic COND_PASSED, // its condition codes passed
   input wire logic EXEC_IS_LS, // it is a load or store
   input wire logic [cophs_pkg::ADDR_W-1:0] TRANSFER_ADDR, // base address for load/store
   input wire logic INTERRUPT_REQ, // interrupt or debug request
   input wire logic CANCEL_REQ, // earlier abort or watchpoint
   input wire logic [1:0] DECODE_HANDSHAKE, // coprocessor decode answer
   input wire logic [1:0] EXECUTE_HANDSHAKE, // coprocessor execute answer
   output logic PIPE_ADVANCE, // pipe advance strobe
   output logic [cophs_pkg::INSTR_W-1:0] FETCHED_INSTRUCTION, // instruction bus
   output logic CONDITION_PASS, // condition pass to coprocessor
   output logic LATE_CANCEL_A, // late cancel to coprocessor
   output logic DATA_MEM_REQUEST_N, // data request, low active
   output logic [cophs_pkg::ADDR_W-1:0] DATA_ADDR, // data transfer address
   output logic CORE_STALL, // core held in execute
   output logic UNDEF_TRAP, // undefined instruction trap
   output logic INSTR_COMMIT, // coprocessor instruction done
   output logic INSTR_ABANDON // busy-wait abandoned
);

   // ----------------------------------------------------------------
   // state and next-state wires
   // ----------------------------------------------------------------
   cophs_pkg::cophs_state_type st_q, st_d;
   logic ls_q;
   logic adv_q, pass_q, cancel_q, req_n_q, stall_q, trap_q, commit_q, abandon_q;
   logic [cophs_pkg::INSTR_W-1:0] instr_q;
   logic [1:0] hs;
   logic start, hs_absent, hs_wait, hs_go, hs_last, in_wait, stall_d, req_n_d;
   logic trap_d, commit_d, abandon_d, ls_d;

   // ----------------------------------------------------------------
   // state decoding shared by several outputs
   // ----------------------------------------------------------------
   // states in which the core pipe is held behind the instruction
   function automatic logic holds_pipe(input cophs_pkg::cophs_state_type s);
      return (s == cophs_pkg::ST_FIRST) || (s == cophs_pkg::ST_WAIT) || (s == cophs_pkg::ST_EXEC);
   endfunction

   // states in which a load/store moves one data word
   // busy-wait moves nothing, so a restart repeats only the word from ST_FIRST
   function automatic logic moves_word(input cophs_pkg::cophs_state_type s);
      return (s == cophs_pkg::ST_FIRST) || (s == cophs_pkg::ST_EXEC) || (s == cophs_pkg::ST_FINAL);
   endfunction

   // decode handshake only on the first execute cycle
   assign hs = (st_q == cophs_pkg::ST_FIRST) ? DECODE_HANDSHAKE : EXECUTE_HANDSHAKE;
   assign hs_absent = (hs == cophs_pkg::HS_ABSENT);
   assign hs_wait = (hs == cophs_pkg::HS_WAIT);
   assign hs_go = (hs == cophs_pkg::HS_GO);
   assign hs_last = (hs == cophs_pkg::HS_LAST);
   assign in_wait = (st_q == cophs_pkg::ST_WAIT);

   // a failed condition never reaches the sequencer
   assign start = (st_q == cophs_pkg::ST_IDLE) && ADVANCE_REQ && EXEC_IS_COP && COND_PASSED;
   assign ls_d = start ? EXEC_IS_LS : ls_q;

   // ----------------------------------------------------------------
   // execute sequencer
   // ----------------------------------------------------------------
   // interrupt beats handshake so a waiting instruction can restart later
   always_comb begin
      st_d = st_q;
      trap_d = 1'b0;
      commit_d = 1'b0;
      abandon_d = 1'b0;
      case (st_q)
         cophs_pkg::ST_IDLE: begin
            if (start) begin
               st_d = cophs_pkg::ST_FIRST;
            end
         end
         cophs_pkg::ST_FIRST, cophs_pkg::ST_EXEC: begin
            if (CANCEL_REQ) begin
               st_d = cophs_pkg::ST_IDLE;
            end else if (hs_absent) begin
               st_d = cophs_pkg::ST_IDLE;
               trap_d = 1'b1;
            end else if (hs_wait) begin
               st_d = (st_q == cophs_pkg::ST_FIRST) ? cophs_pkg::ST_WAIT : cophs_pkg::ST_EXEC;
            end else if (hs_go) begin
               st_d = cophs_pkg::ST_EXEC;
            end else if (ls_q) begin
               st_d = cophs_pkg::ST_FINAL;
            end else begin
               st_d = cophs_pkg::ST_IDLE;
               commit_d = 1'b1;
            end
         end
         cophs_pkg::ST_WAIT: begin
            if (INTERRUPT_REQ || CANCEL_REQ) begin
               st_d = cophs_pkg::ST_IDLE;
               abandon_d = 1'b1;
            end else if (hs_absent) begin
               st_d = cophs_pkg::ST_IDLE;
               trap_d = 1'b1;
            end else if (hs_go) begin
               st_d = cophs_pkg::ST_EXEC;
            end else if (hs_last) begin
               st_d = ls_q ? cophs_pkg::ST_FINAL : cophs_pkg::ST_IDLE;
               commit_d = !ls_q;
            end
         end
         cophs_pkg::ST_FINAL: begin
            st_d = cophs_pkg::ST_IDLE;
            commit_d = 1'b1;
         end
         default: begin
            st_d = cophs_pkg::ST_IDLE;
         end
      endcase
   end

   // core holds its pipe while the instruction needs more execute cycles
   assign stall_d = holds_pipe(st_d);
   // one data word per load/store execute cycle outside busy-wait
   assign req_n_d = !(ls_d && moves_word(st_d));

   // ----------------------------------------------------------------
   // registers, all recirculate when the qualifier is low
   // ----------------------------------------------------------------
   // recirculation rather than a gated clock keeps one clean clock net
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= cophs_pkg::ST_IDLE;
         ls_q <= 1'b0;
         adv_q <= 1'b0;
         pass_q <= 1'b0;
         cancel_q <= 1'b0;
         req_n_q <= 1'b1;
         stall_q <= 1'b0;
         trap_q <= 1'b0;
         commit_q <= 1'b0;
         abandon_q <= 1'b0;
         instr_q <= cophs_pkg::INSTR_RESET;
      end else if (CLOCK_QUALIFIER) begin
         st_q <= st_d;
         ls_q <= ls_d;
         adv_q <= ADVANCE_REQ && !stall_d;
         pass_q <= (st_d != cophs_pkg::ST_IDLE);
         cancel_q <= CANCEL_REQ;
         req_n_q <= req_n_d;
         stall_q <= stall_d;
         trap_q <= trap_d;
         commit_q <= commit_d;
         abandon_q <= abandon_d;
         if (adv_q) begin
            instr_q <= FETCH_DATA;
         end
      end
   end

   // ----------------------------------------------------------------
   // load/store address walk
   // ----------------------------------------------------------------
   cophs_xfer_count u_count (
      .clk(CORE_CLK),
      .rst(RESET),
      .qual(CLOCK_QUALIFIER),
      .load(start),
      .base(TRANSFER_ADDR),
      .step(!req_n_q),
      .addr_q(DATA_ADDR),
      .words_q()
   );

   // outputs straight from flops
   assign PIPE_ADVANCE = adv_q;
   assign FETCHED_INSTRUCTION = instr_q;
   assign CONDITION_PASS = pass_q;
   assign LATE_CANCEL_A = cancel_q;
   assign DATA_MEM_REQUEST_N = req_n_q;
   assign CORE_STALL = stall_q;
   assign UNDEF_TRAP = trap_q;
   assign INSTR_COMMIT = commit_q;
   assign INSTR_ABANDON = abandon_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);

   absent_trap_a: assert property (
      (st_q == cophs_pkg::ST_FIRST) && CLOCK_QUALIFIER && !CANCEL_REQ && DECODE_HANDSHAKE == cophs_pkg::HS_ABSENT
      |=> UNDEF_TRAP && st_q == cophs_pkg::ST_IDLE) else $error("absent decode answer did not trap");
   wait_absent_a: assert property (
      in_wait && CLOCK_QUALIFIER && !INTERRUPT_REQ && !CANCEL_REQ && EXECUTE_HANDSHAKE == cophs_pkg::HS_ABSENT
      |=> UNDEF_TRAP) else $error("absent in busy-wait did not trap");
   wait_go_a: assert property (
      in_wait && CLOCK_QUALIFIER && !INTERRUPT_REQ && !CANCEL_REQ && EXECUTE_HANDSHAKE == cophs_pkg::HS_GO
      |=> st_q == cophs_pkg::ST_EXEC && CONDITION_PASS) else $error("go in busy-wait did not proceed");
   irq_drop_a: assert property (
      in_wait && CLOCK_QUALIFIER && INTERRUPT_REQ |=> !CONDITION_PASS && INSTR_ABANDON)
      else $error("interrupt did not drop pass");
   wait_pass_a: assert property (
      in_wait |-> CONDITION_PASS && CORE_STALL) else $error("pass or stall low in busy-wait");
   hold_still_a: assert property (
      !CLOCK_QUALIFIER |=> $stable(st_q) && $stable(PIPE_ADVANCE)) else $error("state moved unqualified");
   cancel_edge_a: assert property (
      CLOCK_QUALIFIER && CANCEL_REQ |=> LATE_CANCEL_A) else $error("late cancel not driven");
   mem_req_a: assert property (
      !DATA_MEM_REQUEST_N |-> ls_q && st_q != cophs_pkg::ST_IDLE) else $error("data request outside load/store");
   start_pass_a: assert property (
      start && CLOCK_QUALIFIER |=> CONDITION_PASS && st_q == cophs_pkg::ST_FIRST) else $error("pass missing");

   // output flops must track the sequencer they are loaded from
   stall_track_a: assert property (
      CLOCK_QUALIFIER |=> CORE_STALL == holds_pipe(st_q)) else $error("stall does not follow state");
   pass_idle_a: assert property (
      st_q == cophs_pkg::ST_IDLE |-> !CONDITION_PASS) else $error("pass high while idle");
   pass_busy_a: assert property (
      st_q != cophs_pkg::ST_IDLE |-> CONDITION_PASS) else $error("pass low during execute");
   trap_idle_a: assert property (
      UNDEF_TRAP |-> st_q == cophs_pkg::ST_IDLE) else $error("trap while still executing");
   commit_idle_a: assert property (
      INSTR_COMMIT |-> st_q == cophs_pkg::ST_IDLE && !CONDITION_PASS) else $error("commit while executing");
   abandon_idle_a: assert property (
      INSTR_ABANDON |-> st_q == cophs_pkg::ST_IDLE && !CONDITION_PASS) else $error("abandon with pass high");
   one_event_a: assert property (
      $onehot0({UNDEF_TRAP, INSTR_COMMIT, INSTR_ABANDON})) else $error("two end events at once");

   // sequencer steps on each handshake answer
   final_commit_a: assert property (
      st_q == cophs_pkg::ST_FINAL && CLOCK_QUALIFIER |=> INSTR_COMMIT && st_q == cophs_pkg::ST_IDLE)
      else $error("final cycle did not commit");
   first_go_a: assert property (
      st_q == cophs_pkg::ST_FIRST && CLOCK_QUALIFIER && !CANCEL_REQ && DECODE_HANDSHAKE == cophs_pkg::HS_GO
      |=> st_q == cophs_pkg::ST_EXEC) else $error("decode go did not execute");
   exec_go_a: assert property (
      st_q == cophs_pkg::ST_EXEC && CLOCK_QUALIFIER && !CANCEL_REQ && EXECUTE_HANDSHAKE == cophs_pkg::HS_GO
      |=> st_q == cophs_pkg::ST_EXEC) else $error("execute go left execute");
   last_plain_a: assert property (
      (st_q == cophs_pkg::ST_FIRST || st_q == cophs_pkg::ST_EXEC) && CLOCK_QUALIFIER && !CANCEL_REQ && hs_last
      && !ls_q |=> INSTR_COMMIT) else $error("last did not commit");
   last_ls_a: assert property (
      (st_q == cophs_pkg::ST_FIRST || st_q == cophs_pkg::ST_EXEC) && CLOCK_QUALIFIER && !CANCEL_REQ && hs_last
      && ls_q |=> st_q == cophs_pkg::ST_FINAL && !DATA_MEM_REQUEST_N) else $error("last word not moved");
   wait_hold_a: assert property (
      in_wait && CLOCK_QUALIFIER && !INTERRUPT_REQ && !CANCEL_REQ && EXECUTE_HANDSHAKE == cophs_pkg::HS_WAIT
      |=> in_wait && CONDITION_PASS) else $error("busy-wait left on wait");

   // cancel ends an instruction quietly in ST_FIRST or ST_EXEC (in busy-wait it raises INSTR_ABANDON, in ST_FINAL it still commits) and is harmless when idle
   cancel_end_a: assert property (
      (st_q == cophs_pkg::ST_FIRST || st_q == cophs_pkg::ST_EXEC) && CLOCK_QUALIFIER && CANCEL_REQ
      |=> st_q == cophs_pkg::ST_IDLE && !INSTR_COMMIT) else $error("cancelled instruction went on");
   cancel_idle_a: assert property (
      st_q == cophs_pkg::ST_IDLE && CLOCK_QUALIFIER && CANCEL_REQ |=> !UNDEF_TRAP && !INSTR_COMMIT)
      else $error("idle cancel caused an event");
   no_start_a: assert property (
      st_q == cophs_pkg::ST_IDLE && CLOCK_QUALIFIER && !COND_PASSED |=> st_q == cophs_pkg::ST_IDLE)
      else $error("failed condition started");

   // fetch path and data address walk
   advance_stall_a: assert property (
      CORE_STALL |-> !PIPE_ADVANCE) else $error("advance while stalled");
   fetch_take_a: assert property (
      PIPE_ADVANCE && CLOCK_QUALIFIER |=> FETCHED_INSTRUCTION == $past(FETCH_DATA))
      else $error("fetched word not taken");
   addr_step_a: assert property (
      !DATA_MEM_REQUEST_N && CLOCK_QUALIFIER |=> DATA_ADDR == $past(DATA_ADDR) + cophs_pkg::WORD_STEP)
      else $error("data address did not step");

   busy_wait_c: cover property (in_wait ##1 in_wait ##1 st_q == cophs_pkg::ST_EXEC);
   multi_word_c: cover property (!DATA_MEM_REQUEST_N [*3] ##1 INSTR_COMMIT);
   abandon_c: cover property (in_wait ##1 INSTR_ABANDON);
   trap_c: cover property (in_wait ##1 UNDEF_TRAP);
   cancel_c: cover property (st_q == cophs_pkg::ST_EXEC && CANCEL_REQ ##1 st_q == cophs_pkg::ST_IDLE);

endmodule

// [cophs_cop_model.sv]
`timescale 1ns/1ps
module cophs_cop_model (
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   input wire logic qual, // clock qualifier
   input wire logic adv, // pipe advance strobe
   input wire logic [31:0] instr, // instruction bus
   input wire logic pass, // condition pass
   input wire logic [7:0] n_wait, // wait answers first
   input wire logic [7:0] n_go, // go answers before last
   input wire logic absent, // absent after the waits
   output logic [1:0] dec_hs, // decode handshake
   output logic [1:0] exe_hs // execute handshake
);
   logic [31:0] fet_q, dec_q, exe_q;
   logic [7:0] cnt_q;
   // ------------------------------------------
   // follower pipeline and answer script
   // ------------------------------------------
   // shifts only on a qualified advance, empty after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fet_q <= 32'h0000_0000;
         dec_q <= 32'h0000_0000;
         exe_q <= 32'h0000_0000;
      end else if (qual && adv) begin
         fet_q <= instr;
         dec_q <= fet_q;
         exe_q <= dec_q;
      end
   end
   // nothing moves without pass, so an abandoned op restarts clean
   // runs off the plain clock net by recirculation, never a gated one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cnt_q <= 8'h00;
      else if (qual) cnt_q <= pass ? cnt_q + 8'h01 : 8'h00;
   end
   // waits, then absent or gos, then last
   function automatic logic [1:0] answer(input logic [7:0] k, w, g, input logic ab);
      if (k < w) return cophs_pkg::HS_WAIT;
      if (ab) return cophs_pkg::HS_ABSENT;
      if (k < w + g) return cophs_pkg::HS_GO;
      return cophs_pkg::HS_LAST;
   endfunction
   assign dec_hs = answer(8'h00, n_wait, n_go, absent);
   assign exe_hs = answer(cnt_q, n_wait, n_go, absent);
endmodule

// [test_coprocessor_handshake_follower.sv]
`timescale 1ns/1ps
module test_coprocessor_handshake_follower;
   logic CORE_CLK, RESET, CLOCK_QUALIFIER, ADVANCE_REQ, EXEC_IS_COP, COND_PASSED, EXEC_IS_LS;
   logic INTERRUPT_REQ, CANCEL_REQ, PIPE_ADVANCE, CONDITION_PASS, LATE_CANCEL_A, DATA_MEM_REQUEST_N;
   logic CORE_STALL, UNDEF_TRAP, INSTR_COMMIT, INSTR_ABANDON, absent, prev_req;
   logic [31:0] FETCH_DATA, TRANSFER_ADDR, FETCHED_INSTRUCTION, DATA_ADDR, base, prev_addr, r;
   logic [7:0] n_wait, n_go;
   logic [1:0] DECODE_HANDSHAKE, EXECUTE_HANDSHAKE, ev;
   logic [1:0] exp_q[$];
   logic prev_can = 1'b0, prev_adv = 1'b0;
   logic [31:0] exp_instr = 32'h0000_0000;
   int error_cnt, num_checks, pass_cnt, seed, k, tnum;
   // ------------------------------------------
   // design and partner
   // ------------------------------------------
   cophs_core_port cophs_core_port_i (.CORE_CLK(CORE_CLK), .RESET(RESET), .CLOCK_QUALIFIER(CLOCK_QUALIFIER),
      .ADVANCE_REQ(ADVANCE_REQ), .FETCH_DATA(FETCH_DATA), .EXEC_IS_COP(EXEC_IS_COP), .COND_PASSED(COND_PASSED),
      .EXEC_IS_LS(EXEC_IS_LS), .TRANSFER_ADDR(TRANSFER_ADDR), .INTERRUPT_REQ(INTERRUPT_REQ),
      .CANCEL_REQ(CANCEL_REQ), .DECODE_HANDSHAKE(DECODE_HANDSHAKE), .EXECUTE_HANDSHAKE(EXECUTE_HANDSHAKE),
      .PIPE_ADVANCE(PIPE_ADVANCE), .FETCHED_INSTRUCTION(FETCHED_INSTRUCTION), .CONDITION_PASS(CONDITION_PASS),
      .LATE_CANCEL_A(LATE_CANCEL_A), .DATA_MEM_REQUEST_N(DATA_MEM_REQUEST_N), .DATA_ADDR(DATA_ADDR),
      .CORE_STALL(CORE_STALL), .UNDEF_TRAP(UNDEF_TRAP), .INSTR_COMMIT(INSTR_COMMIT),
      .INSTR_ABANDON(INSTR_ABANDON));
   cophs_cop_model cophs_cop_model_i (.clk(CORE_CLK), .rst(RESET), .qual(CLOCK_QUALIFIER),
      .adv(PIPE_ADVANCE), .instr(FETCHED_INSTRUCTION), .pass(CONDITION_PASS), .n_wait(n_wait),
      .n_go(n_go), .absent(absent), .dec_hs(DECODE_HANDSHAKE), .exe_hs(EXECUTE_HANDSHAKE));
   // ------------------------------------------
   // clock, random qualifier and fetch words
   // ------------------------------------------
   initial begin
      CORE_CLK = 1'b0;
      forever #10 CORE_CLK = ~CORE_CLK;
   end
   // unqualified edges must freeze everything
   always @(negedge CORE_CLK) begin
      CLOCK_QUALIFIER <= ($random(seed) & 3) != 0;
      FETCH_DATA <= $random(seed);
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------------------
   // watcher: outputs seen before the edge updates them
   // ------------------------------------------
   always @(posedge CORE_CLK) begin
      if (!RESET && CLOCK_QUALIFIER) begin
         ev = INSTR_COMMIT ? 2'h1 : UNDEF_TRAP ? 2'h2 : INSTR_ABANDON ? 2'h3 : 2'h0;
         if (ev != 2'h0) chk("event", exp_q.size() ? exp_q.pop_front() : 2'h0, ev);
         if (CONDITION_PASS) pass_cnt++;
         if (!DATA_MEM_REQUEST_N) chk("data address", prev_req ? base : prev_addr + 32'h4, DATA_ADDR);
         prev_req = DATA_MEM_REQUEST_N;
         prev_addr = DATA_ADDR;
         if (prev_adv) chk("fetched instruction", exp_instr, FETCHED_INSTRUCTION);
         prev_adv = PIPE_ADVANCE;
         exp_instr = FETCH_DATA;
         chk("late cancel", {31'h0, prev_can}, {31'h0, LATE_CANCEL_A});
         prev_can = CANCEL_REQ;
      end
   end
   task qedge;
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge CORE_CLK);
         if (CLOCK_QUALIFIER) break;
      end
      if (i == 50) chk("qualified edge", 1, 0);
   endtask
   // one instruction; interrupt and cancel stay up from their cycle on
   task run(input int w, g, input logic ab, ls, cp, input int irq, can, input logic [1:0] e);
      int i, p0;
      @(negedge CORE_CLK);
      n_wait = w[7:0];
      n_go = g[7:0];
      absent = ab;
      base = $random(seed) & 32'hFFFF_FFFC;
      TRANSFER_ADDR = base;
      EXEC_IS_COP = 1'b1;
      COND_PASSED = cp;
      EXEC_IS_LS = ls;
      p0 = pass_cnt;
      if (e != 2'h0) exp_q.push_back(e);
      qedge();
      @(negedge CORE_CLK);
      EXEC_IS_COP = 1'b0;
      for (i = 0; i < 600 && (i < 4 || CORE_STALL !== 1'b0 || exp_q.size() != 0); i++) begin
         INTERRUPT_REQ = i >= irq;
         CANCEL_REQ = i >= can;
         @(negedge CORE_CLK);
      end
      INTERRUPT_REQ = 1'b0;
      CANCEL_REQ = 1'b0;
      if (i == 600) chk("completion", 0, 1);
      repeat (3) qedge();
      chk("pass seen", {31'h0, cp}, 32'(pass_cnt > p0));
      tnum++;
      $display("test %0d done", tnum);
   endtask
   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      seed = 32'hA01B1C21;
      {RESET, CLOCK_QUALIFIER, ADVANCE_REQ, prev_req, absent} = 5'h1F;
      {EXEC_IS_COP, COND_PASSED, EXEC_IS_LS, INTERRUPT_REQ, CANCEL_REQ} = 5'h00;
      FETCH_DATA = 32'h0000_0000;
      TRANSFER_ADDR = 32'h0000_0000;
      n_wait = 8'h00;
      n_go = 8'h00;
      repeat (12) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
      RESET = 1'b0;
      run(0, 0, 1, 0, 1, 999, 999, 2'h2);
      run(3, 0, 1, 0, 1, 999, 999, 2'h2);
      run(2, 0, 0, 0, 1, 999, 999, 2'h1);
      run(0, 3, 0, 1, 1, 999, 999, 2'h1);
      run(0, 0, 0, 1, 1, 999, 999, 2'h1);
      run(200, 0, 0, 0, 1, 5, 999, 2'h3);
      run(0, 5, 0, 0, 1, 999, 1, 2'h0);
      run(0, 0, 0, 0, 0, 999, 999, 2'h0);
      run(0, 0, 0, 0, 0, 999, 0, 2'h0);
      for (k = 0; k < 6; k++) begin
         r = $random(seed);
         run(r[0] ? 0 : r[2:1], r[4:3], 1'b0, r[0], 1'b1, 999, 999, 2'h1);
      end
      stop_test();
   end
endmodule
